// >>> common/ext_irq_pkg.sv
/*
 * Shared constants and types for the external interrupt control block.
 * Assumes a 32-bit APB register bus and a single 50 MHz clock.
 */
package ext_irq_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   // Printed offsets are not all multiples of four, so they act as word indices.
   localparam logic [11:0] clock_enable_index = 12'hf77;
   localparam logic [11:0] irq1_control_index = 12'hfd8;
   localparam logic [13:0] clock_enable_addr = {clock_enable_index, 2'h0};
   localparam logic [13:0] irq1_control_addr = {irq1_control_index, 2'h0};
   localparam int addr_width = 14;

   // ************************************************************
   // Field layouts and reset values
   // ************************************************************
   localparam int num_inputs = 6;
   localparam int sample_sel_lsb = 0;
   localparam int edge_sel_lsb = 2;
   localparam int level_snap_pos = 4;
   localparam logic [5:0] clock_enable_reset = 6'h00;
   localparam logic [1:0] edge_sel_reset = 2'h0;
   localparam logic [1:0] sample_sel_reset = 2'h0;

   // ************************************************************
   // Encodings
   // ************************************************************
   localparam logic [1:0] edge_rising = 2'h0;
   localparam logic [1:0] edge_falling = 2'h1;
   localparam logic [1:0] edge_both = 2'h2;
   localparam logic [1:0] edge_reserved = 2'h3;

   // ************************************************************
   // Timing constants
   // ************************************************************
   // Gear clock divisors as powers of two for sample select codes 0 to 3.
   localparam logic [3:0] gear_div_log2_tab = 4'h0;
   localparam int low_freq_div = 4;
   localparam int filter_hold_ticks = 3;

   // Control fields of the interrupt 1 control register.
   typedef struct packed {
      logic [1:0] edge_sel;
      logic [1:0] sample_sel;
   } irq1_ctrl_t;

endpackage

// >>> dv/board_pins.sv
/* Board side of the six interrupt pins and the free-running low clock.
   Assumes the bench asks for pin levels through the level input. */
`timescale 1ns/10ps
module board_pins (
   input wire logic pclk,
   input wire logic [5:0] level,
   output logic [5:0] irq_pin,
   output logic low_freq_clock
);
   // Pins move just after an edge; the low clock is unrelated to pclk.
   initial irq_pin = 6'h00;
   initial low_freq_clock = 1'b0;
   always @(posedge pclk) irq_pin <= level;
   always #75 low_freq_clock = ~low_freq_clock;
endmodule

// >>> dv/eic_monitor.sv
/* Port checker for the external interrupt control block.
   Assumes the bind at the foot attaches it to every instance. */
`timescale 1ns/10ps
module eic_monitor import ext_irq_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [5:0] irq_pin,
   input wire logic low_speed_mode,
   input wire logic low_freq_clock,
   input wire logic [5:0] latch_accept,
   input wire logic [5:0] latch_clear,
   input wire logic [5:0] irq_latch,
   input wire logic [5:0] filtered_level
);
   // Decode and latch bits that should survive the next edge.
   wire en_hit = paddr == {18'h0, clock_enable_addr};
   wire ctl_hit = paddr == {18'h0, irq1_control_addr};
   wire rd_acc = psel && penable && !pwrite;
   wire [5:0] keep = irq_latch & ~latch_accept & ~latch_clear;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   mapped_ok_a: assert property (psel && penable && (en_hit || ctl_hit) |-> !pslverr)
      else $error("error on mapped");
   unmapped_err_a: assert property (rd_acc && !en_hit && !ctl_hit |-> pslverr && prdata == 0)
      else $error("unmapped read");
   en_upper_a:
      assert property (rd_acc && en_hit |-> prdata[31:6] == 26'h0) else $error("enable upper");
   ctl_upper_a:
      assert property (rd_acc && ctl_hit |-> prdata[31:5] == 27'h0) else $error("ctl upper");
   latch_hold_a:
      assert property (1'b1 |=> (irq_latch & $past(keep)) == $past(keep)) else $error("dropped");
   accept_drop_a:
      assert property (latch_accept[0] && !filtered_level[0] |=> !irq_latch[0] || filtered_level[0])
      else $error("accept ignored");
   clear_drop_a:
      assert property (latch_clear[1] && !filtered_level[1] |=> !irq_latch[1] || filtered_level[1])
      else $error("clear ignored");
   rise_high_a:
      assert property ($rose(irq_latch[0]) |-> filtered_level[0]) else $error("rise on low");
   still_quiet_a:
      assert property ($stable(filtered_level[0]) [*3] |-> !$rose(irq_latch[0]))
      else $error("request without edge");
endmodule
bind external_interrupt_control eic_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .irq_pin(irq_pin), .low_speed_mode(low_speed_mode),
   .low_freq_clock(low_freq_clock), .latch_accept(latch_accept), .latch_clear(latch_clear),
   .irq_latch(irq_latch), .filtered_level(filtered_level));

// >>> dv/tb_top.sv
/* Self-checking bench for the external interrupt control block.
   Assumes the pin model drives the pins and the checker is bound in. */
`timescale 1ns/10ps
`define check(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
   $display("unexpected %s expected %h seen %h", what, exp, got); end end
module tb_top;
   import ext_irq_pkg::*;
   localparam int ht = 2;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic pready, pslverr, err, low_speed_mode = 1'b0, low_freq_clock;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
   logic [5:0] level = 6'h00, irq_pin, irq_latch, filtered_level;
   logic [5:0] latch_accept = 6'h00, latch_clear = 6'h00;
   int bad_count = 0, n_compared = 0, cycles = 0, lat;
   always #10 pclk = ~pclk;
   external_interrupt_control #(.hold_ticks(ht)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq_pin(irq_pin), .low_speed_mode(low_speed_mode),
      .low_freq_clock(low_freq_clock), .latch_accept(latch_accept), .latch_clear(latch_clear),
      .irq_latch(irq_latch), .filtered_level(filtered_level));
   board_pins pins (.pclk(pclk), .level(level), .irq_pin(irq_pin), .low_freq_clock(low_freq_clock));
   // One APB transfer; the idle cycle after it keeps psel to one assignment per step.
   task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {18'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && cycles < 20000) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Count cycles until the filtered level follows, then let the latch land.
   task automatic wait_filt(input int i, input logic v);
      lat = 0;
      while (filtered_level[i] !== v && lat < 3000) begin
         lat++;
         @(posedge pclk);
      end
      repeat (3) @(posedge pclk);
   endtask
   task automatic clr();
      latch_clear <= 6'h3f;
      @(posedge pclk);
      latch_clear <= 6'h00;
      @(posedge pclk);
   endtask
   task automatic t_regs();
      apb(1'b0, clock_enable_addr, 0);
      `check("enable reset", 32'h0, rd)
      apb(1'b1, clock_enable_addr, 32'hff);
      apb(1'b0, clock_enable_addr, 0);
      `check("enable read", 32'h3f, rd)
      apb(1'b1, irq1_control_addr, 32'hff);
      apb(1'b0, irq1_control_addr, 0);
      `check("control read", 32'h0f, rd)
      apb(1'b0, 14'h0004, 0);
      `check("unmapped", 1'b1, err)
      `check("ready", 1'b1, pready)
   endtask
   task automatic t_gated();
      // Inputs 1 and 3 off: the control write is lost and pin 3 is ignored.
      apb(1'b1, clock_enable_addr, 32'h35);
      apb(1'b1, irq1_control_addr, 32'h09);
      level[3] <= 1'b1;
      repeat (12) @(posedge pclk);
      `check("gated filter", 1'b0, filtered_level[3])
      `check("gated latch", 1'b0, irq_latch[3])
      level[3] <= 1'b0;
      repeat (6) @(posedge pclk);
      apb(1'b1, clock_enable_addr, 32'h3f);
      apb(1'b0, irq1_control_addr, 0);
      `check("gated write", 32'h0f, rd)
      // no CPU mask here, so latches are cleared after the toggle
      clr();
   endtask
   task automatic t_glitch();
      level[0] <= 1'b1;
      @(posedge pclk);
      level[0] <= 1'b0;
      repeat (12) @(posedge pclk);
      `check("glitch", 1'b0, filtered_level[0])
      level[0] <= 1'b1;
      wait_filt(0, 1'b1);
      `check("input0 rise", 1'b1, irq_latch[0])
      level[0] <= 1'b0;
      wait_filt(0, 1'b0);
      latch_accept <= 6'h01;
      @(posedge pclk);
      latch_accept <= 6'h00;
      repeat (2) @(posedge pclk);
      `check("accepted", 1'b0, irq_latch[0])
   endtask
   // Sweep the sample rates, then the edge codes, on input 1.
   task automatic t_rate();
      int div;
      for (int s = 0; s < 4; s++) begin
         div = (s == 0) ? 1 : (1 << (s + 1));
         apb(1'b1, irq1_control_addr, 32'(s));
         clr();
         level[1] <= 1'b1;
         wait_filt(1, 1'b1);
         `check("rate", 1'b1, lat >= (ht - 1) * div + 5 && lat <= ht * div + 6)
         level[1] <= 1'b0;
         wait_filt(1, 1'b0);
         `check("held", 1'b1, irq_latch[1])
         apb(1'b0, irq1_control_addr, 0);
         `check("snapshot high", 1'b1, rd[4])
      end
   endtask
   task automatic t_edges();
      for (int c = 1; c < 4; c++) begin
         apb(1'b1, irq1_control_addr, 32'(c << 2));
         clr();
         level[1] <= 1'b1;
         wait_filt(1, 1'b1);
         `check("on rise", c == 2, irq_latch[1])
         level[1] <= 1'b0;
         wait_filt(1, 1'b0);
         `check("on fall", c != 3, irq_latch[1])
         apb(1'b0, irq1_control_addr, 0);
         `check("snapshot low", 1'b0, rd[4])
      end
   endtask
   task automatic t_slow();
      apb(1'b1, irq1_control_addr, 0);
      // no CPU mask here, so the latch is cleared after the switch
      low_speed_mode <= 1'b1;
      repeat (90) @(posedge pclk);
      clr();
      level[1] <= 1'b1;
      wait_filt(1, 1'b1);
      `check("slow rate", 1'b1, lat >= (ht - 1) * 28 && lat <= ht * 32 + 24)
      low_speed_mode <= 1'b0;
      // two gear plus three sample periods
      repeat (5) @(posedge pclk);
      clr();
      `check("cleared", 1'b0, irq_latch[1])
   endtask
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // A hang counts as a mismatch; the run needs a few hundred cycles.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         give_verdict();
      end
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_gated();
      t_glitch();
      t_rate();
      t_edges();
      t_slow();
      give_verdict();
   end
endmodule

// >>> src/external_interrupt_control.sv
/*
 * External interrupt control: a clock-enable register for six inputs, a
 * noise canceller and edge detector per input, and the interrupt 1 control
 * register, all behind an APB slave.
 * Assumes pins are asynchronous, the gear clock equals pclk, and the CPU
 * side acknowledges each latch with a one-cycle accept pulse.
 */
// Behaviour
// - Six enable bits, cleared at reset, gate each input's interrupt logic.
// - Control register writes are lost while input 1 is disabled.
// - Toggling an enable bit may raise a spurious request.
// - Enable register bits seven and six read as zero.
// - Status bit captures filtered level when interrupt 1 request fires.
// - Edge select: 00 rising, 01 falling, 10 both, 11 reserved.
// - At full speed, sample at gear clock divided by 1, 4, 8, 16.
// - At low speed, sample at low clock divided by four always.
// - Mode changes may raise a spurious request.
// - Writing the interrupt 1 control register may raise a spurious request.
// - Control register bits seven to five read zero; reset is zero.
// - Detectors see only the noise canceller output.
// - A latch holds until accepted, cleared by software, or reset.
`timescale 1ns/10ps
module external_interrupt_control #(
   parameter int inputs = ext_irq_pkg::num_inputs,
   parameter int hold_ticks = ext_irq_pkg::filter_hold_ticks
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [5:0] irq_pin,
   input wire logic low_speed_mode,
   input wire logic low_freq_clock,
   input wire logic [5:0] latch_accept,
   input wire logic [5:0] latch_clear,
   output logic [5:0] irq_latch,
   output logic [5:0] filtered_level
);
   import ext_irq_pkg::*;

   initial begin
      if (inputs != num_inputs) begin
         $error("inputs must equal six");
      end
      if (hold_ticks < 1) begin
         $error("hold_ticks must be at least one");
      end
   end

   // ************************************************************
   // Register bus decode
   // ************************************************************
   logic [5:0] input_enable_bit;
   irq1_ctrl_t irq1_ctrl;
   logic filtered_level_snapshot;

   // An aligned word inside the decoded window; anything else is unmapped.
   function automatic logic word_hit(input logic [31:0] addr,
         input logic [addr_width-1:0] target);
      return addr[1:0] == 2'h0 && addr[31:addr_width] == '0 &&
         addr[addr_width-1:0] == target;
   endfunction

   wire access = psel && penable;
   wire hit_enable = word_hit(paddr, clock_enable_addr);
   wire hit_ctrl1 = word_hit(paddr, irq1_control_addr);
   wire mapped = hit_enable || hit_ctrl1;
   wire wr_enable = access && pwrite && hit_enable;
   wire wr_ctrl1 = access && pwrite && hit_ctrl1;

   // The slave answers in the first access cycle; unmapped addresses error.
   assign pready = 1'b1;
   assign pslverr = access && !mapped;

   wire [31:0] enable_word = {26'h0, input_enable_bit};
   wire [31:0] ctrl1_word = {27'h0, filtered_level_snapshot,
      irq1_ctrl.edge_sel, irq1_ctrl.sample_sel};
   wire [31:0] read_word = hit_enable ? enable_word :
      (hit_ctrl1 ? ctrl1_word : 32'h0);

   // Read data is registered so it comes from a flip-flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= read_word;
      end
   end

   // ************************************************************
   // Clock enable register
   // ************************************************************
   // Enable bits reset clear.
   // Toggle glitch permitted.
   // Writes act at once; a frozen filter may catch up and fire on re-enable.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_enable_bit <= clock_enable_reset;
      end else if (wr_enable) begin
         input_enable_bit <= pwdata[5:0];
      end
   end

   // ************************************************************
   // Interrupt 1 control register
   // ************************************************************
   // Writes need enable.
   // The write is dropped rather than stored, as the register is unclocked then.
   // Rewrite glitch permitted.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq1_ctrl.edge_sel <= edge_sel_reset;
         irq1_ctrl.sample_sel <= sample_sel_reset;
      end else if (wr_ctrl1 && input_enable_bit[1]) begin
         irq1_ctrl.edge_sel <= pwdata[edge_sel_lsb +: 2];
         irq1_ctrl.sample_sel <= pwdata[sample_sel_lsb +: 2];
      end
   end

   // ************************************************************
   // Pin and low clock synchronisers
   // ************************************************************
   logic [6:0] sync_a;
   logic [6:0] sync_b;
   logic low_clk_prev;

   // Two stages per asynchronous input; only sync_b feeds any logic.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= 7'h00;
         sync_b <= 7'h00;
         low_clk_prev <= 1'b0;
      end else begin
         sync_a <= {low_freq_clock, irq_pin};
         sync_b <= sync_a;
         low_clk_prev <= sync_b[6];
      end
   end

   wire [5:0] pin_sync = sync_b[5:0];
   wire low_clk_rise = sync_b[6] && !low_clk_prev;

   // ************************************************************
   // Sample tick dividers
   // ************************************************************
   logic [3:0] gear_count;
   logic [1:0] low_count;

   // Free-running dividers; a tick is a one-cycle enable pulse.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gear_count <= 4'h0;
         low_count <= 2'h0;
      end else begin
         gear_count <= gear_count + 4'h1;
         if (low_clk_rise) begin
            low_count <= low_count + 2'h1;
         end
      end
   end

   // Mask of low gear counter bits that must be zero for a tick.
   function automatic logic [3:0] gear_mask(input logic [1:0] sel);
      logic [3:0] m;
      m = 4'h0;
      unique case (sel)
         2'h0: m = 4'h0;
         2'h1: m = 4'h3;
         2'h2: m = 4'h7;
         2'h3: m = 4'hf;
      endcase
      return m;
   endfunction

   wire low_tick = low_clk_rise && low_count == 2'(low_freq_div - 1);
   // Inputs other than 1 have no control register here, so they sample at full rate.
   wire gear_tick_base = (gear_count & gear_mask(sample_sel_reset)) == 4'h0;
   wire gear_tick_1 = (gear_count & gear_mask(irq1_ctrl.sample_sel)) == 4'h0;

   // Request condition of one input from its edge code and filtered history.
   function automatic logic edge_match(input logic [1:0] code, input logic now,
         input logic was);
      logic hit;
      hit = 1'b0;
      unique case (code)
         edge_rising: hit = now && !was;
         edge_falling: hit = !now && was;
         edge_both: hit = now != was;
         edge_reserved: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // ************************************************************
   // Filters, edge detectors and latches
   // ************************************************************
   logic [5:0] filt_prev;
   logic [5:0] edge_hit;
   wire [5:0] filt;

   genvar i;
   generate
      for (i = 0; i < 6; i++) begin : g_in
         // Mode switch glitch permitted.
         // The filter keeps its count across a rate change, so one hold may be short.
         wire tick_i = low_speed_mode ? low_tick :
            (i == 1 ? gear_tick_1 : gear_tick_base);
         noise_filter #(
            .hold_ticks(hold_ticks)
         ) u_filter (
            .pclk(pclk),
            .presetn(presetn),
            .run(input_enable_bit[i]),
            .tick(tick_i),
            .raw(pin_sync[i]),
            .filtered(filt[i])
         );
         wire [1:0] es = (i == 1) ? irq1_ctrl.edge_sel : edge_sel_reset;
         // Edge selection; reserved code never fires.
         assign edge_hit[i] = input_enable_bit[i] && edge_match(es, filt[i], filt_prev[i]);
      end
   endgenerate

   wire [5:0] latch_drop = latch_accept | latch_clear;

   // Latch holds; a new edge wins over a clear in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_prev <= 6'h00;
         irq_latch <= 6'h00;
         filtered_level <= 6'h00;
      end else begin
         filt_prev <= filt;
         irq_latch <= edge_hit | (irq_latch & ~latch_drop);
         filtered_level <= filt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filtered_level_snapshot <= 1'b0;
      end else if (edge_hit[1]) begin
         filtered_level_snapshot <= filt[1];
      end
   end
endmodule

// >>> src/noise_filter.sv
/*
 * Noise canceller for one external input: the filtered output follows the
 * input once it has held one level for a fixed count of sample ticks.
 * Assumes the input is already synchronised to pclk.
 */
`timescale 1ns/10ps
module noise_filter #(
   parameter int hold_ticks = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic tick,
   input wire logic raw,
   output logic filtered
);
   import ext_irq_pkg::*;

   localparam int cw = $clog2(hold_ticks + 1);

   initial begin
      if (hold_ticks < 1) begin
         $error("hold_ticks must be at least one");
      end
   end

   logic [cw-1:0] count;
   wire differs = raw != filtered;
   wire at_limit = count == cw'(hold_ticks - 1);

   // ************************************************************
   // Stable-level counter
   // ************************************************************
   // Hold count filter.
   // A stopped clock gate (run low) freezes the filter as real gating would.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
         filtered <= 1'b0;
      end else if (run && tick) begin
         if (!differs) begin
            count <= '0;
         end else if (at_limit) begin
            count <= '0;
            filtered <= raw;
         end else begin
            count <= count + cw'(1);
         end
      end
   end
endmodule
